// File: hw/rpr_defines.svh
`ifndef RPR_DEFINES_SVH
`define RPR_DEFINES_SVH
// Summary of operation
// (RQ1) region setup uses only the locator and attribute control registers.
// (RQ2) software writes start, index and kind into the locator register.
// (RQ3) kind bit one selects a data region, zero an instruction region.
// (RQ4) start field holds start address divided by the region granule.
// (RQ5) region number is unique; lower number means higher overlap priority.
// (RQ6) software writes zeros into unused upper bits of the number field.
// (RQ7) software zeros unused upper and lower bits of start, size, end.
// (RQ8) build option picks size field or end field; only one exists.
// (RQ9) size variant: size field defines the selected region size.
// (RQ10) end variant: end field defines the upper address bound.
// (RQ11) memory type: 0 peripheral, 1 normal, 2 device, 3 reserved.
// (RQ12) access rights field holds permissions of the selected region.
// (RQ13) attribute write with fetch flag set performs a region read.
// (RQ14) attribute write with store flag set performs a region write.
// (RQ15) size field is 0xFFFFFF shifted by log2(size/256); zero is 4 GB.
// (RQ16) end field holds address just past the last byte, in granules.
// (RQ17) instruction rights: 000 none, 001 supervisor exec, 010 both exec.
// (RQ18) data rights 000,001,010,100,101,110 give none through both read/write.
// (RQ19) region read copies stored fields to registers; region write stores them.
// (RQ20) all readable fields of both registers reset to zero.
`define RPR_SEL_LOCATOR 1'b0
`define RPR_SEL_ATTRIB 1'b1
`define RPR_KIND_BIT 0
`define RPR_IDX_LSB 1
`define RPR_IDX_W 5
`define RPR_START_LSB 6
`define RPR_START_W 26
`define RPR_STORE_BIT 0
`define RPR_FETCH_BIT 1
`define RPR_RIGHTS_LSB 2
`define RPR_RIGHTS_W 3
`define RPR_MTYPE_LSB 5
`define RPR_MTYPE_W 2
`define RPR_BOUND_LSB 8
`define RPR_BOUND_W 24
`define RPR_NREG 32
`define RPR_RESET_WORD 32'h0000_0000
`define RPR_MT_PERIPH 2'h0
`define RPR_MT_NORMAL 2'h1
`define RPR_MT_DEVICE 2'h2
`define RPR_MT_RSVD 2'h3
`endif

// File: hw/rpr_pkg.sv
`include "rpr_defines.svh"
package rpr_pkg;
  typedef logic [`RPR_START_W-1:0] rpr_start_t;
  typedef logic [`RPR_BOUND_W-1:0] rpr_bound_t;
  typedef logic [`RPR_RIGHTS_W-1:0] rpr_rights_t;
  typedef logic [`RPR_MTYPE_W-1:0] rpr_mtype_t;
  typedef logic [`RPR_IDX_W-1:0] rpr_idx_t;
  typedef enum logic [1:0] {
    RPR_IDLE = 2'b01,
    RPR_LOAD = 2'b10
  } rpr_state_t;
endpackage

// File: hw/rpr_regs.sv
`timescale 1ns/1ps
`include "rpr_defines.svh"
module rpr_regs
  import rpr_pkg::*;
#(
  // size or end meaning of the bound field; storage is the same either way
  parameter bit USE_END_BOUND = 1'b0 // RQ8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // control-register port from the core
  input wire logic ctlWrEn,
  input wire logic ctlSel,
  input wire logic [31:0] ctlWrData,
  input wire logic ctlRdEn,
  output logic [31:0] ctlRdData,
  // current register contents for the checking logic
  output logic dataKind,
  output rpr_idx_t regionIndex,
  output rpr_start_t regionStart,
  output rpr_bound_t regionBound,
  output rpr_mtype_t memory_type_field,
  output rpr_rights_t access_rights_field,
  output logic tableBusy
);

  // table of stored regions, one per index and kind
  rpr_start_t startMem [2*`RPR_NREG];
  rpr_bound_t boundMem [2*`RPR_NREG];
  rpr_mtype_t mtypeMem [2*`RPR_NREG];
  rpr_rights_t rightsMem [2*`RPR_NREG];

  logic kind_q, kind_d;
  rpr_idx_t idx_q, idx_d;
  rpr_start_t start_q, start_d;
  rpr_bound_t bound_q, bound_d;
  rpr_mtype_t mtype_q, mtype_d;
  rpr_rights_t rights_q, rights_d;
  rpr_state_t state_q, state_d;
  logic [31:0] rd_q, rd_d;
  logic [5:0] slot;
  logic doStore, doFetch;
  logic memWe;
  rpr_bound_t memBound;
  rpr_mtype_t memMtype;
  rpr_rights_t memRights;

  // data regions sit in the upper half of the table
  assign slot = {kind_q, idx_q}; // RQ3 RQ5
  assign doStore = ctlWrEn && ctlSel == `RPR_SEL_ATTRIB && ctlWrData[`RPR_STORE_BIT]; // RQ14
  // both flags at once is undefined; fetch is simply dropped then
  assign doFetch = ctlWrEn && ctlSel == `RPR_SEL_ATTRIB && ctlWrData[`RPR_FETCH_BIT] && !doStore; // RQ13

  // next register values
  always_comb begin
    kind_d = kind_q;
    idx_d = idx_q;
    start_d = start_q;
    bound_d = bound_q;
    mtype_d = mtype_q;
    rights_d = rights_q;
    state_d = state_q;
    case (state_q)
      RPR_IDLE: begin
        if (ctlWrEn && ctlSel == `RPR_SEL_LOCATOR) begin // RQ1 RQ2
          kind_d = ctlWrData[`RPR_KIND_BIT]; // RQ3
          idx_d = ctlWrData[`RPR_IDX_LSB +: `RPR_IDX_W]; // RQ5 RQ6
          start_d = ctlWrData[`RPR_START_LSB +: `RPR_START_W]; // RQ4 RQ7
        end else if (ctlWrEn && ctlSel == `RPR_SEL_ATTRIB) begin
          bound_d = ctlWrData[`RPR_BOUND_LSB +: `RPR_BOUND_W]; // RQ8 RQ9 RQ10 RQ15 RQ16
          mtype_d = ctlWrData[`RPR_MTYPE_LSB +: `RPR_MTYPE_W]; // RQ11
          rights_d = ctlWrData[`RPR_RIGHTS_LSB +: `RPR_RIGHTS_W]; // RQ12 RQ17 RQ18
          if (doFetch) begin
            state_d = RPR_LOAD; // RQ13
          end
        end
      end
      RPR_LOAD: begin
        // region read: table contents replace the register fields
        start_d = startMem[slot]; // RQ19
        bound_d = boundMem[slot];
        mtype_d = mtypeMem[slot];
        rights_d = rightsMem[slot];
        state_d = RPR_IDLE;
      end
      default: begin
        state_d = RPR_IDLE;
      end
    endcase
  end

  // register stage, synchronous reset to zero, state to RPR_IDLE
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      kind_q <= 1'b0; // RQ20
      idx_q <= '0;
      start_q <= '0;
      bound_q <= '0;
      mtype_q <= '0;
      rights_q <= '0;
      state_q <= RPR_IDLE;
    end else begin
      kind_q <= kind_d;
      idx_q <= idx_d;
      start_q <= start_d;
      bound_q <= bound_d;
      mtype_q <= mtype_d;
      rights_q <= rights_d;
      state_q <= state_d;
    end
  end

  // region write uses the locator already held and the incoming attributes
  always_comb begin
    memWe = doStore && state_q == RPR_IDLE; // RQ14
    memBound = ctlWrData[`RPR_BOUND_LSB +: `RPR_BOUND_W];
    memMtype = ctlWrData[`RPR_MTYPE_LSB +: `RPR_MTYPE_W];
    memRights = ctlWrData[`RPR_RIGHTS_LSB +: `RPR_RIGHTS_W];
  end

  // table is not reset: a slot is undefined until its first store
  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      startMem[slot] <= start_q; // RQ19
      boundMem[slot] <= memBound;
      mtypeMem[slot] <= memMtype;
      rightsMem[slot] <= memRights;
    end
  end

  // read data; flags read as zero being write-only
  always_comb begin
    rd_d = rd_q;
    if (ctlRdEn) begin
      if (ctlSel == `RPR_SEL_LOCATOR) begin
        rd_d = {start_q, idx_q, kind_q};
      end else begin
        rd_d = {bound_q, 1'b0, mtype_q, rights_q, 2'b00}; // RQ13 RQ14
      end
    end
  end

  // read word is held so the core may take it a cycle later
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_q <= `RPR_RESET_WORD;
    end else begin
      rd_q <= rd_d;
    end
  end

  // field outputs straight from the flops; only tableBusy is decoded from the state
  assign ctlRdData = rd_q;
  assign dataKind = kind_q;
  assign regionIndex = idx_q;
  assign regionStart = start_q;
  assign regionBound = bound_q;
  assign memory_type_field = mtype_q;
  assign access_rights_field = rights_q;
  assign tableBusy = (state_q == RPR_LOAD);

  // a fetch is one load cycle, then the table data sits in the fields
  sequence s_fetch_req;
    doFetch && state_q == RPR_IDLE;
  endsequence

  sequence s_load_once;
    tableBusy ##1 !tableBusy;
  endsequence

  // a store takes the held locator as the slot address
  sequence s_store_req;
    ctlWrEn && ctlSel == `RPR_SEL_ATTRIB && ctlWrData[`RPR_STORE_BIT] && state_q == RPR_IDLE;
  endsequence

  // fetch timing and the fields it replaces
  a_fetch_loads: assert property (@(posedge clk_sys) disable iff (srst) // RQ13
    s_fetch_req |=> s_load_once) else $error("fetch did not take one cycle");
  a_fetch_copies: assert property (@(posedge clk_sys) disable iff (srst) // RQ19
    tableBusy |=> rights_q == $past(rightsMem[slot])) else $error("fetch copy wrong");
  a_fetch_start: assert property (@(posedge clk_sys) disable iff (srst) // RQ19
    tableBusy |=> start_q == $past(startMem[slot])) else $error("fetched start wrong");
  a_fetch_bound: assert property (@(posedge clk_sys) disable iff (srst) // RQ19
    tableBusy |=> bound_q == $past(boundMem[slot])) else $error("fetched bound wrong");
  a_fetch_mtype: assert property (@(posedge clk_sys) disable iff (srst) // RQ19
    tableBusy |=> mtype_q == $past(mtypeMem[slot])) else $error("fetched memory type wrong");

  // stores land in the slot picked by kind and index
  a_store_start: assert property (@(posedge clk_sys) disable iff (srst) // RQ19
    s_store_req |=> startMem[$past(slot)] == $past(start_q)) else $error("stored start wrong");
  a_store_attr: assert property (@(posedge clk_sys) disable iff (srst) // RQ14
    s_store_req |=> rightsMem[$past(slot)] == $past(ctlWrData[`RPR_RIGHTS_LSB +: `RPR_RIGHTS_W]) &&
      mtypeMem[$past(slot)] == $past(ctlWrData[`RPR_MTYPE_LSB +: `RPR_MTYPE_W]))
    else $error("stored attributes wrong");
  a_store_bound: assert property (@(posedge clk_sys) disable iff (srst) // RQ14
    s_store_req |=> boundMem[$past(slot)] == $past(ctlWrData[`RPR_BOUND_LSB +: `RPR_BOUND_W]))
    else $error("stored bound wrong");

  // locator and attribute writes when no load is under way
  a_loc_write: assert property (@(posedge clk_sys) disable iff (srst) // RQ5
    ctlWrEn && ctlSel == `RPR_SEL_LOCATOR && !tableBusy |=> idx_q == $past(ctlWrData[5:1]))
    else $error("index not stored");
  a_kind_write: assert property (@(posedge clk_sys) disable iff (srst) // RQ3
    ctlWrEn && ctlSel == `RPR_SEL_LOCATOR && !tableBusy |=> dataKind == $past(ctlWrData[0]))
    else $error("kind not stored");
  a_start_write: assert property (@(posedge clk_sys) disable iff (srst) // RQ4
    ctlWrEn && ctlSel == `RPR_SEL_LOCATOR && !tableBusy |=> start_q == $past(ctlWrData[31:6]))
    else $error("start not stored");
  a_attr_write: assert property (@(posedge clk_sys) disable iff (srst) // RQ11
    ctlWrEn && ctlSel == `RPR_SEL_ATTRIB && !tableBusy |=> mtype_q == $past(ctlWrData[6:5]))
    else $error("memory type not stored");
  a_bound_write: assert property (@(posedge clk_sys) disable iff (srst) // RQ9
    ctlWrEn && ctlSel == `RPR_SEL_ATTRIB && !tableBusy |=> bound_q == $past(ctlWrData[31:8]))
    else $error("bound not stored");

  // without a write or a load the fields keep their values
  a_loc_holds: assert property (@(posedge clk_sys) disable iff (srst) // RQ5
    !ctlWrEn && !tableBusy |=> $stable(start_q) && $stable(idx_q) && $stable(kind_q))
    else $error("locator changed on its own");
  a_attr_holds: assert property (@(posedge clk_sys) disable iff (srst) // RQ12
    !ctlWrEn && !tableBusy |=> $stable(bound_q) && $stable(mtype_q) && $stable(rights_q))
    else $error("attributes changed on their own");

  // write-only flags and reset
  a_flags_hidden: assert property (@(posedge clk_sys) disable iff (srst) // RQ14
    ctlRdEn && ctlSel == `RPR_SEL_ATTRIB |=> ctlRdData[1:0] == 2'b00)
    else $error("write-only flags read back");
  a_reset_zero: assert property (@(posedge clk_sys) // RQ20
    srst |=> ctlRdData == `RPR_RESET_WORD && regionIndex == '0 && !tableBusy)
    else $error("reset not zero");

endmodule // rpr_regs

// File: bench/rpr_core_model.sv
`timescale 1ns/1ps
module rpr_core_model (
  // clock
  input wire logic clk_sys,
  // control-register port toward the block
  output logic ctlWrEn,
  output logic ctlSel,
  output logic [31:0] ctlWrData,
  output logic ctlRdEn
);
  // idle bus at time zero
  initial begin
    ctlWrEn = 1'b0;
    ctlSel = 1'b0;
    ctlWrData = 32'h0000_0000;
    ctlRdEn = 1'b0;
  end
  // one write; data is inverted afterwards so stale data never looks valid
  task automatic wr(input logic sel, input logic [31:0] data);
    ctlWrEn <= 1'b1;
    ctlSel <= sel;
    ctlWrData <= data;
    @(posedge clk_sys);
    ctlWrEn <= 1'b0;
    ctlWrData <= ~data;
    @(posedge clk_sys);
  endtask
  // one read strobe; the idle cycle after it keeps strobes apart
  task automatic rd(input logic sel);
    ctlRdEn <= 1'b1;
    ctlSel <= sel;
    @(posedge clk_sys);
    ctlRdEn <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule // rpr_core_model

// File: bench/region_protection_registers_bench.sv
`timescale 1ns/1ps
module region_protection_registers_bench;
  logic clk_sys, srst, ctlWrEn, ctlSel, ctlRdEn, rdPend;
  logic [31:0] ctlWrData, ctlRdData, loc, att, att2, e, obs;
  logic dataKind, tableBusy, rdSel;
  logic [4:0] regionIndex;
  logic [25:0] regionStart;
  logic [23:0] regionBound;
  logic [1:0] memory_type_field;
  logic [2:0] access_rights_field;
  logic [31:0] expQ[$];
  int n_fail, compares, cycles, seed, busyCycles;
  // clock and idle state
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    rdPend = 1'b0;
    cycles = 0;
    n_fail = 0;
    compares = 0;
    busyCycles = 0;
  end
  rpr_core_model i_core (.clk_sys(clk_sys), .ctlWrEn(ctlWrEn), .ctlSel(ctlSel), .ctlWrData(ctlWrData),
    .ctlRdEn(ctlRdEn));
  rpr_regs i_dut (.clk_sys(clk_sys), .srst(srst), .ctlWrEn(ctlWrEn), .ctlSel(ctlSel), .ctlWrData(ctlWrData),
    .ctlRdEn(ctlRdEn), .ctlRdData(ctlRdData), .dataKind(dataKind), .regionIndex(regionIndex),
    .regionStart(regionStart), .regionBound(regionBound), .memory_type_field(memory_type_field),
    .access_rights_field(access_rights_field), .tableBusy(tableBusy));
  task automatic test_done();
    $display("counts: compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // note the expectation, then issue the read
  task automatic rdExp(input logic sel, input logic [31:0] v);
    expQ.push_back(v);
    i_core.rd(sel);
  endtask
  // read data is settled one edge after the strobe was taken
  always @(posedge clk_sys) begin
    if (rdPend) begin
      e = expQ.pop_front();
      compares++;
      if (ctlRdData !== e) begin
        n_fail++;
        $display("ERROR t=%0t got %h exp %h", $time, ctlRdData, e);
      end
      // field outputs must show the same word as the read path
      obs = rdSel ? {regionBound, 1'b0, memory_type_field, access_rights_field, 2'b00} :
        {regionStart, regionIndex, dataKind};
      compares++;
      if (obs !== e) begin
        n_fail++;
        $display("ERROR t=%0t got %h exp %h", $time, obs, e);
      end
    end
    rdPend = ctlRdEn;
    rdSel = ctlSel;
  end
  // load cycles counted on the falling edge, away from the launching edge
  always @(negedge clk_sys) begin
    if (tableBusy === 1'b1) begin
      busyCycles++;
    end
  end
  // hang guard, generous against roughly 190 cycles of tests
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    seed = 80;
    srst = 1'b1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rdExp(1'b0, 32'h0000_0000);
    rdExp(1'b1, 32'h0000_0000);
    $display("test reset values done");
    // every locator bit is a live field here
    loc = $random(seed);
    i_core.wr(1'b0, loc);
    rdExp(1'b0, loc);
    // all type and rights codes; flags and bit 7 must read zero
    for (int i = 0; i < 32; i++) begin
      att = $random(seed) & 32'hFFFF_FF7C;
      att[6:2] = i[4:0];
      i_core.wr(1'b1, att);
      rdExp(1'b1, att);
    end
    $display("test field codes done");
    // same index, both kinds, stored apart then fetched back
    att = $random(seed) & 32'hFFFF_FF7C;
    att2 = $random(seed) & 32'hFFFF_FF7C;
    i_core.wr(1'b0, {loc[31:6], 5'h1f, 1'b1});
    i_core.wr(1'b1, att | 32'h0000_0001);
    i_core.wr(1'b0, {loc[31:6], 5'h1f, 1'b0});
    i_core.wr(1'b1, att2 | 32'h0000_0001);
    for (int k = 1; k >= 0; k--) begin
      i_core.wr(1'b0, {~loc[31:6], 5'h1f, k[0]});
      i_core.wr(1'b1, 32'h0000_0002);
      repeat (2) @(posedge clk_sys);
      rdExp(1'b0, {loc[31:6], 5'h1f, k[0]});
      rdExp(1'b1, k[0] ? att : att2);
    end
    // the two fetches together must hold the table busy for exactly two cycles
    compares++;
    if (busyCycles != 2) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, busyCycles, 2);
    end
    $display("test store and fetch done");
    // reset in mid-run must wipe the loaded fields
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rdExp(1'b0, 32'h0000_0000);
    rdExp(1'b1, 32'h0000_0000);
    $display("test mid-run reset done");
    repeat (3) @(posedge clk_sys);
    test_done();
  end
endmodule // region_protection_registers_bench
